// *** design/nvm_cfg.svh ***
// Purpose: Constants of the nonvolatile access front end.
// Assumes: Included by its bare name wherever the values are needed.
// Notes:   Times are in nanoseconds; cycle counts are derived in the module.
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH
// ----------------------------------------------------------------------------
// Register selects on the special function register port
// ----------------------------------------------------------------------------
`define NVM_SEL_CTRL      3'h0
`define NVM_SEL_UNLOCK    3'h1
`define NVM_SEL_DATA_LO   3'h2
`define NVM_SEL_DATA_HI   3'h3
`define NVM_SEL_ADDR_LO   3'h4
`define NVM_SEL_ADDR_HI   3'h5
// ----------------------------------------------------------------------------
// Control register bit positions and reset values
// ----------------------------------------------------------------------------
`define NVM_BIT_PGD       7
`define NVM_BIT_WRITE_ABORT_FLAG     3
`define NVM_BIT_WRITE_ALLOW      2
`define NVM_BIT_WR        1
`define NVM_BIT_RD        0
`define NVM_REG_RST       8'h00
`define NVM_UNLOCK_KEY1   8'h55
`define NVM_UNLOCK_KEY2   8'haa
// ----------------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------------
`define NVM_DEE_BYTES     256
`define NVM_PM_WORDS      4096
`define NVM_CLK_PERIOD_NS 20
`define NVM_ERASE_TIME_NS 2000
`define NVM_PROG_TIME_NS  2000
`endif

// *** design/nvm_pkg.sv ***
// Purpose: Types of the nonvolatile access front end.
// Assumes: Constants live in nvm_cfg.svh.
// Notes:   Module state is one packed struct, apart from the abort and busy shadow flops and the arrays.
package nvm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_ERASE, ST_PROG} nvm_state_e;
  typedef struct packed {
    logic pgd;
    logic write_allow;
    logic wr;
    logic rd;
  } nvm_ctrl_s;
  typedef struct packed {
    nvm_ctrl_s  ctrl;
    nvm_state_e st;
    logic [15:0] cnt;
    logic [1:0]  unlock;
    logic [7:0]  data_lo;
    logic [5:0]  data_hi;
    logic [7:0]  addr_lo;
    logic [4:0]  addr_hi;
    logic        done;
    logic        busy;
    logic [7:0]  rdata;
    logic [13:0] icsp_rdata;
  } nvm_state_s;
endpackage

// *** design/nvm_access_ctrl.sv ***
// Purpose: Register front end for data EEPROM and program flash access.
// Assumes: Single clock, synchronous inputs, one register access per cycle.
// Notes:   Arrays are held here; the array write time is an internal timer.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cfg.svh"

module nvm_access_ctrl
  import nvm_pkg::*;
#(
  parameter int PM_WORDS  = `NVM_PM_WORDS,
  parameter int DEE_BYTES = `NVM_DEE_BYTES
)(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_por,
  input  wire logic        i_warm_rst_cause,
  input  wire logic [2:0]  i_sfr_sel,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_done_clr,
  input  wire logic [1:0]  i_self_write_protect,
  input  wire logic        i_code_protect,
  input  wire logic        i_icsp_rd,
  input  wire logic        i_icsp_wr,
  input  wire logic        i_icsp_pgm,
  input  wire logic [12:0] i_icsp_addr,
  input  wire logic [13:0] i_icsp_wdata,
  output logic [7:0]       o_sfr_rdata,
  output logic             o_write_done_flag,
  output logic             o_write_abort_flag,
  output logic             o_busy,
  output logic [13:0]      o_icsp_rdata
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam int PM_AW = $clog2(PM_WORDS);
  localparam int DE_AW = $clog2(DEE_BYTES);
  // Phase times round up to whole cycles, so a slower clock never shortens a phase.
  // A zero result is raised to one cycle so the counter always has something to count.
  localparam int ERASE_INT = (`NVM_ERASE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS;
  localparam int PROG_INT  = (`NVM_PROG_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS;
  localparam logic [15:0] ERASE_CYC = 16'(ERASE_INT < 1 ? 1 : ERASE_INT);
  localparam logic [15:0] PROG_CYC  = 16'(PROG_INT < 1 ? 1 : PROG_INT);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // The arrays have no reset, so their contents stay unknown until first written.
  logic [7:0]  dee_mem [DEE_BYTES];
  logic [13:0] pm_mem  [PM_WORDS];

  nvm_state_s s_q;
  nvm_state_s s_d;
  logic       abort_q;
  logic       busy_shadow_q;
  logic       dee_we;
  logic [7:0] dee_wval;
  logic [DE_AW-1:0] cpu_de_addr;
  logic [PM_AW-1:0] cpu_pm_addr;

  // Decode a register write to one select.
  function automatic logic sel_wr(input logic [2:0] sel);
    return i_sfr_wr && (i_sfr_sel == sel);
  endfunction

  // Data space uses only the low address byte; program space joins both.
  assign cpu_de_addr = DE_AW'(s_q.addr_lo);
  assign cpu_pm_addr = PM_AW'({s_q.addr_hi, s_q.addr_lo});

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // One process owns every field of the state struct; CPU writes to the data array follow from its decisions.
  always_comb
  begin
    s_d      = s_q;
    dee_we   = 1'b0;
    dee_wval = dee_mem[cpu_de_addr];
    // Plain data and address registers; unused upper bits are never stored.
    if (sel_wr(`NVM_SEL_DATA_LO))
      s_d.data_lo = i_sfr_wdata;
    if (sel_wr(`NVM_SEL_DATA_HI))
      s_d.data_hi = i_sfr_wdata[5:0];
    if (sel_wr(`NVM_SEL_ADDR_LO))
      s_d.addr_lo = i_sfr_wdata;
    if (sel_wr(`NVM_SEL_ADDR_HI))
      s_d.addr_hi = i_sfr_wdata[4:0];
    // The unlock port only tracks the two-key sequence.
    if (sel_wr(`NVM_SEL_UNLOCK))
    begin
      if (i_sfr_wdata == `NVM_UNLOCK_KEY1)
        s_d.unlock = 2'h1;
      else if (i_sfr_wdata == `NVM_UNLOCK_KEY2 && s_q.unlock == 2'h1)
        s_d.unlock = 2'h2;
      else
        s_d.unlock = 2'h0;
    end
    // Control writes: start bits may only be set, never cleared.
    if (sel_wr(`NVM_SEL_CTRL))
    begin
      s_d.ctrl.pgd  = i_sfr_wdata[`NVM_BIT_PGD];
      s_d.ctrl.write_allow = i_sfr_wdata[`NVM_BIT_WRITE_ALLOW];
      s_d.unlock    = 2'h0;
      if (s_q.st == ST_IDLE && i_sfr_wdata[`NVM_BIT_RD])
      begin
        s_d.ctrl.rd = 1'b1;
        s_d.st      = ST_READ;
      end
      else if (s_q.st == ST_IDLE && i_sfr_wdata[`NVM_BIT_WR] && s_q.ctrl.write_allow && !s_q.ctrl.pgd
               && s_q.unlock == 2'h2)
      begin
        // A refused start leaves both the start bit and the arrays alone.
        s_d.ctrl.wr = 1'b1;
        s_d.st      = ST_ERASE;
        s_d.cnt     = ERASE_CYC - 16'h1;
        s_d.busy    = 1'b1;
      end
    end
    case (s_q.st)
      ST_IDLE:
        // The counter keeps what a start loaded; copying it back here would undo that load.
        s_d.busy = (s_d.st == ST_ERASE);
      ST_READ:
      begin
        // One word per read; the protect setting is not consulted here.
        if (s_q.ctrl.pgd)
        begin
          s_d.data_lo = pm_mem[cpu_pm_addr][7:0];
          s_d.data_hi = pm_mem[cpu_pm_addr][13:8];
        end
        else
          s_d.data_lo = dee_mem[cpu_de_addr];
        s_d.ctrl.rd = 1'b0;
        s_d.st      = ST_IDLE;
      end
      ST_ERASE:
      begin
        // Erase phase ends with the byte blank before programming starts.
        if (s_q.cnt == 16'h0)
        begin
          dee_we   = 1'b1;
          dee_wval = 8'hff;
          s_d.st   = ST_PROG;
          s_d.cnt  = PROG_CYC - 16'h1;
        end
        else
          s_d.cnt = s_q.cnt - 16'h1;
      end
      ST_PROG:
      begin
        if (s_q.cnt == 16'h0)
        begin
          dee_we      = 1'b1;
          dee_wval    = s_q.data_lo;
          s_d.ctrl.wr = 1'b0;
          s_d.done    = 1'b1;
          s_d.busy    = 1'b0;
          s_d.st      = ST_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - 16'h1;
      end
      default:
        s_d.st = ST_IDLE;
    endcase
    // Done flag: a finishing write in the clearing cycle wins.
    if (i_done_clr && !(s_q.st == ST_PROG && s_q.cnt == 16'h0))
      s_d.done = 1'b0;
    // Read mux of the register port; unlock and unmapped read zero.
    if (i_sfr_sel == `NVM_SEL_CTRL)
    begin
      s_d.rdata                 = `NVM_REG_RST;
      s_d.rdata[`NVM_BIT_PGD]   = s_q.ctrl.pgd;
      s_d.rdata[`NVM_BIT_WRITE_ABORT_FLAG] = abort_q;
      s_d.rdata[`NVM_BIT_WRITE_ALLOW]  = s_q.ctrl.write_allow;
      s_d.rdata[`NVM_BIT_WR]    = s_q.ctrl.wr;
      s_d.rdata[`NVM_BIT_RD]    = s_q.ctrl.rd;
    end
    else if (i_sfr_sel == `NVM_SEL_DATA_LO)
      s_d.rdata = s_q.data_lo;
    else if (i_sfr_sel == `NVM_SEL_DATA_HI)
      s_d.rdata = {2'h0, s_q.data_hi};
    else if (i_sfr_sel == `NVM_SEL_ADDR_LO)
      s_d.rdata = s_q.addr_lo;
    else if (i_sfr_sel == `NVM_SEL_ADDR_HI)
      s_d.rdata = {3'h0, s_q.addr_hi};
    else
      s_d.rdata = `NVM_REG_RST;
    // External programmer sees nothing while code protection is on.
    if (i_code_protect)
      s_d.icsp_rdata = 14'h0;
    else if (i_icsp_rd)
      s_d.icsp_rdata = i_icsp_pgm ? pm_mem[PM_AW'(i_icsp_addr)]
                                  : {6'h0, dee_mem[DE_AW'(i_icsp_addr)]};
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Everything returns to data space with writes disallowed.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      s_q <= '0;
    else if (i_ce)
      s_q <= s_d;
  end

  // --------------------------------------------------------------------------
  // Abort flag that outlives a warm reset
  // --------------------------------------------------------------------------
  // The shadow copies busy while out of reset and holds through it, so the
  // edge that sees reset still knows a write was cut short. Reset never clears it;
  // power-on or a control write with the abort bit low does, which is why neither flop sits on the asynchronous reset.
  always_ff @(posedge i_mclk)
  begin
    if (i_por)
    begin
      busy_shadow_q <= 1'b0;
      abort_q       <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!i_rst)
        busy_shadow_q <= s_d.busy;
      if (i_rst && i_warm_rst_cause && busy_shadow_q)
        abort_q <= 1'b1;
      else if (!i_rst && sel_wr(`NVM_SEL_CTRL) && !i_sfr_wdata[`NVM_BIT_WRITE_ABORT_FLAG])
        abort_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Arrays
  // --------------------------------------------------------------------------
  // Program flash is written only by the external programmer when allowed.
  // A CPU data write and a programmer data write never both land: the CPU path wins.
  always_ff @(posedge i_mclk)
  begin
    if (i_ce && !i_rst)
    begin
      if (dee_we)
        dee_mem[cpu_de_addr] <= dee_wval;
      else if (i_icsp_wr && !i_code_protect && !i_icsp_pgm)
        dee_mem[DE_AW'(i_icsp_addr)] <= i_icsp_wdata[7:0];
      if (i_icsp_wr && !i_code_protect && i_icsp_pgm)
        pm_mem[PM_AW'(i_icsp_addr)] <= i_icsp_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every output is a flop of the state struct or the abort flop.
  assign o_sfr_rdata        = s_q.rdata;
  assign o_write_done_flag  = s_q.done;
  assign o_write_abort_flag = abort_q;
  assign o_busy             = s_q.busy;
  assign o_icsp_rdata       = s_q.icsp_rdata;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // The checks share the core clock and sleep through reset.
  // The abort flag checks name their own disable, since that flag must
  // be watched while reset is high.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_read_clears: assert property ((s_q.st == ST_READ && i_ce) |=> !s_q.ctrl.rd && s_q.st == ST_IDLE)
    else $error("read start bit not cleared");
  chk_write_gated: assert property ((s_q.st == ST_IDLE && i_ce && s_d.st == ST_ERASE)
    |-> s_q.ctrl.write_allow && !s_q.ctrl.pgd)
    else $error("write started without permission");
  chk_erase_to_prog: assert property ((s_q.st == ST_ERASE && s_q.cnt == 16'h0 && i_ce)
    |=> s_q.st == ST_PROG && s_q.cnt == PROG_CYC - 16'h1)
    else $error("erase did not hand over to program");
  chk_done_sets: assert property ((s_q.st == ST_PROG && s_q.cnt == 16'h0 && i_ce)
    |=> o_write_done_flag && !s_q.ctrl.wr && !o_busy)
    else $error("done flag missing at write end");
  chk_done_sticky: assert property ((o_write_done_flag && !i_done_clr) |=> o_write_done_flag)
    else $error("done flag dropped without clear");
  chk_wr_holds: assert property ((s_q.ctrl.wr && !(s_q.st == ST_PROG && s_q.cnt == 16'h0))
    |=> s_q.ctrl.wr)
    else $error("write start bit cleared early");
  chk_unlock_zero: assert property ((i_ce && i_sfr_sel == `NVM_SEL_UNLOCK) |=> o_sfr_rdata == 8'h00)
    else $error("unlock port read nonzero");
  chk_data_hi_top: assert property ((i_ce && i_sfr_sel == `NVM_SEL_DATA_HI) |=> o_sfr_rdata[7:6] == 2'h0)
    else $error("data high top bits nonzero");
  chk_icsp_denied: assert property ((i_ce && i_code_protect) |=> o_icsp_rdata == 14'h0)
    else $error("programmer read while protected");
  chk_refused_write: assert property ((s_q.st == ST_IDLE && i_ce && sel_wr(`NVM_SEL_CTRL) && s_q.ctrl.pgd)
    |=> s_q.st != ST_ERASE && !s_q.ctrl.wr)
    else $error("program space write started");

  // A start must load the full erase time; a stale counter would shorten the phase.
  chk_erase_start: assert property ((i_ce && s_q.st == ST_IDLE && s_d.st == ST_ERASE)
    |=> s_q.st == ST_ERASE && s_q.cnt == ERASE_CYC - 16'h1)
    else $error("erase did not start with the full count");
  // The abort flag lives outside the reset domain, so only power-on may disarm these two.
  chk_abort_sets: assert property (disable iff (i_por)
    (i_ce && i_rst && i_warm_rst_cause && busy_shadow_q) |=> o_write_abort_flag)
    else $error("cut write left no abort flag");
  chk_abort_survives: assert property (disable iff (i_por)
    (o_write_abort_flag && i_rst) |=> o_write_abort_flag)
    else $error("abort flag lost in reset");

  // Covers for the main scenarios: both reads, a finished write, a refused start
  // and a program read under a write-protect setting.
  cov_data_read: cover property (s_q.st == ST_READ && !s_q.ctrl.pgd);
  cov_prog_read: cover property (s_q.st == ST_READ && s_q.ctrl.pgd);
  cov_write_done: cover property (s_q.st == ST_PROG && s_q.cnt == 16'h0 && i_ce);
  cov_write_refused: cover property (sel_wr(`NVM_SEL_CTRL) && i_sfr_wdata[`NVM_BIT_WR] && !s_q.ctrl.write_allow);
  cov_prog_read_wp: cover property (s_q.st == ST_READ && s_q.ctrl.pgd && i_self_write_protect != 2'h3);

endmodule // nvm_access_ctrl
`default_nettype wire

// *** tb/tb_nvm_access_ctrl.sv ***
// Purpose: Self-checking bench for the nonvolatile access front end.
// Assumes: nvm_cfg.svh is on the include path; one clock at 50 MHz.
// Notes:   Drivers queue expected results; a negedge monitor compares them.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cfg.svh"
module tb_nvm_access_ctrl;
  typedef struct packed {logic [2:0] kind; logic [13:0] ev;} nvm_note_s;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        por  = 1'b1;
  logic        warm = 1'b0;
  logic [2:0]  sel  = 3'h0;
  logic        swr  = 1'b0;
  logic [7:0]  wd   = 8'h00;
  logic        dclr = 1'b0;
  logic        ce   = 1'b1;
  logic [1:0]  swp  = 2'h0;
  logic        cp   = 1'b0;
  logic        ird  = 1'b0;
  logic        iwr  = 1'b0;
  logic        ipgm = 1'b0;
  logic [12:0] iad  = 13'h0000;
  logic [13:0] iwd  = 14'h0000;
  logic [7:0]  rdata;
  logic        done_f;
  logic        abort_f;
  logic        busy;
  logic [13:0] irdata;
  nvm_note_s   notes[$];
  nvm_note_s   nt;
  logic        chk = 1'b0;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          k;
  logic [31:0] seed = 32'h0000_0161;
  logic [7:0]  a;
  logic [7:0]  d;
  logic [11:0] pa;
  logic [13:0] pw;

  // The clock enable is driven so that one scenario can freeze the block.
  nvm_access_ctrl dut (.i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_por(por), .i_warm_rst_cause(warm),
    .i_sfr_sel(sel), .i_sfr_wr(swr), .i_sfr_wdata(wd), .i_done_clr(dclr), .i_self_write_protect(swp),
    .i_code_protect(cp), .i_icsp_rd(ird), .i_icsp_wr(iwr), .i_icsp_pgm(ipgm), .i_icsp_addr(iad),
    .i_icsp_wdata(iwd), .o_sfr_rdata(rdata), .o_write_done_flag(done_f), .o_write_abort_flag(abort_f),
    .o_busy(busy), .o_icsp_rdata(irdata));

  always #10 mclk = ~mclk;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp1(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic cmp14(input string n, input logic [13:0] e, input logic [13:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------------
  // Expected results are queued one edge after the cause so the monitor sees settled outputs.
  task automatic note(input logic [2:0] kd, input logic [13:0] e);
    @(posedge mclk);
    notes.push_back({kd, e});
    chk <= 1'b1;
  endtask

  task automatic regw(input logic [2:0] s, input logic [7:0] v);
    @(posedge mclk);
    sel <= s;
    wd  <= v;
    swr <= 1'b1;
    @(posedge mclk);
    swr <= 1'b0;
  endtask

  task automatic regr(input logic [2:0] s, input logic [7:0] e);
    @(posedge mclk);
    sel <= s;
    note(3'h0, {6'h00, e});
  endtask

  task automatic unl;
    regw(`NVM_SEL_UNLOCK, `NVM_UNLOCK_KEY1);
    regw(`NVM_SEL_UNLOCK, `NVM_UNLOCK_KEY2);
  endtask

  task automatic ee_read(input logic [7:0] ad, input logic [7:0] e);
    regw(`NVM_SEL_ADDR_LO, ad);
    regw(`NVM_SEL_CTRL, 8'h05);
    repeat (3) @(posedge mclk);
    regr(`NVM_SEL_DATA_LO, e);
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 400)
    begin
      @(negedge mclk);
      i++;
    end
  endtask

  task automatic iw(input logic [12:0] ad, input logic [13:0] v);
    @(posedge mclk);
    ipgm <= 1'b1;
    iad  <= ad;
    iwd  <= v;
    iwr  <= 1'b1;
    @(posedge mclk);
    iwr  <= 1'b0;
  endtask

  task automatic ir(input logic [12:0] ad, input logic [13:0] e);
    @(posedge mclk);
    ipgm <= 1'b1;
    iad  <= ad;
    ird  <= 1'b1;
    @(posedge mclk);
    ird  <= 1'b0;
    note(3'h4, e);
  endtask

  // ----------------------------------------------------------------------------
  // Monitor and watchdog
  // ----------------------------------------------------------------------------
  // Sampling on the falling edge keeps the comparison clear of the launch edge.
  always @(negedge mclk)
  begin
    if (chk)
    begin
      nt = notes.pop_front();
      case (nt.kind)
        3'h0: cmp8("sfr_rdata", nt.ev[7:0], rdata);
        3'h1: cmp1("write_done_flag", nt.ev[0], done_f);
        3'h2: cmp1("write_abort_flag", nt.ev[0], abort_f);
        3'h3: cmp1("busy", nt.ev[0], busy);
        default: cmp14("icsp_rdata", nt.ev, irdata);
      endcase
      chk <= 1'b0;
    end
  end

  // The whole sequence needs under 3000 cycles, so this ceiling only trips on a hang.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      fails++;
      complete_run;
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    por <= 1'b0;
    regr(`NVM_SEL_CTRL, 8'h00);
    regr(3'h6, 8'h00);
    regr(3'h7, 8'h00);
    regw(`NVM_SEL_DATA_HI, 8'hff);
    regr(`NVM_SEL_DATA_HI, 8'h3f);
    regw(`NVM_SEL_ADDR_HI, 8'hff);
    regr(`NVM_SEL_ADDR_HI, 8'h1f);
    regw(`NVM_SEL_UNLOCK, 8'h5a);
    regr(`NVM_SEL_UNLOCK, 8'h00);
    // Byte writes at both ends of the array and at one random place.
    for (k = 0; k < 3; k++)
    begin
      seed = xs(seed);
      a = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
      d = seed[15:8];
      regw(`NVM_SEL_ADDR_LO, a);
      regw(`NVM_SEL_DATA_LO, d);
      regw(`NVM_SEL_CTRL, 8'h04);
      unl;
      regw(`NVM_SEL_CTRL, 8'h06);
      note(3'h3, 14'h0001);
      regw(`NVM_SEL_CTRL, 8'h04);
      regr(`NVM_SEL_CTRL, 8'h06);
      wait_idle;
      note(3'h1, 14'h0001);
      regr(`NVM_SEL_CTRL, 8'h04);
      @(posedge mclk);
      dclr <= 1'b1;
      @(posedge mclk);
      dclr <= 1'b0;
      note(3'h1, 14'h0000);
      ee_read(a, d);
    end
    // Starts without write allow, then with program space, must both be refused.
    // Data low holds another byte, so a start that slipped through shows in the read-back.
    regw(`NVM_SEL_DATA_LO, ~d);
    regw(`NVM_SEL_CTRL, 8'h00);
    unl;
    regw(`NVM_SEL_CTRL, 8'h02);
    regr(`NVM_SEL_CTRL, 8'h00);
    note(3'h3, 14'h0000);
    regw(`NVM_SEL_CTRL, 8'h84);
    unl;
    regw(`NVM_SEL_CTRL, 8'h86);
    regr(`NVM_SEL_CTRL, 8'h84);
    ee_read(a, d);
    // Program words loaded by the programmer, read back one word at a time.
    for (k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      pa = (k == 0) ? seed[27:16] : 12'hfff;
      pw = seed[13:0];
      iw({1'b0, pa}, pw);
      swp <= seed[31:30];
      regw(`NVM_SEL_ADDR_HI, {4'h0, pa[11:8]});
      regw(`NVM_SEL_ADDR_LO, pa[7:0]);
      regw(`NVM_SEL_CTRL, 8'h81);
      repeat (3) @(posedge mclk);
      regr(`NVM_SEL_DATA_LO, pw[7:0]);
      regr(`NVM_SEL_DATA_HI, {2'h0, pw[13:8]});
      regr(`NVM_SEL_CTRL, 8'h80);
    end
    // Code protection blocks the programmer but not the CPU.
    cp <= 1'b1;
    ir({1'b0, pa}, 14'h0000);
    iw({1'b0, pa}, ~pw);
    regw(`NVM_SEL_CTRL, 8'h81);
    repeat (3) @(posedge mclk);
    regr(`NVM_SEL_DATA_LO, pw[7:0]);
    cp <= 1'b0;
    ir({1'b0, pa}, pw);
    // A warm reset in mid-write leaves the abort flag standing.
    regw(`NVM_SEL_DATA_LO, 8'h3c);
    // With the clock enable low a register write must leave no trace.
    ce <= 1'b0;
    regw(`NVM_SEL_DATA_LO, 8'h11);
    ce <= 1'b1;
    regr(`NVM_SEL_DATA_LO, 8'h3c);
    regw(`NVM_SEL_CTRL, 8'h04);
    unl;
    regw(`NVM_SEL_CTRL, 8'h06);
    repeat (50) @(posedge mclk);
    rst  <= 1'b1;
    warm <= 1'b1;
    repeat (2) @(posedge mclk);
    rst  <= 1'b0;
    warm <= 1'b0;
    note(3'h2, 14'h0001);
    note(3'h3, 14'h0000);
    regr(`NVM_SEL_CTRL, 8'h08);
    @(posedge mclk);
    por <= 1'b1;
    @(posedge mclk);
    por <= 1'b0;
    note(3'h2, 14'h0000);
    repeat (3) @(posedge mclk);
    complete_run;
  end
endmodule // tb_nvm_access_ctrl
`default_nettype wire
